// ==== inc/csv_pkg.sv ====
// Constants shared by the CAN status vector and error state block
package csv_pkg;

	// ********************************************************
	// Register byte offsets on the APB
	// ********************************************************
	localparam logic [7:0] OFF_VEC = 8'h00; // Source code and filter hit
	localparam logic [7:0] OFF_TREC = 8'h04; // Error counts and states
	localparam logic [7:0] OFF_FSTAT = 8'h08; // FIFO pending summary
	localparam logic [7:0] OFF_OVFSUM = 8'h0c; // FIFO overflow summary
	localparam logic [7:0] OFF_ISTAT = 8'h10; // Sticky event status
	localparam logic [7:0] OFF_IMASK = 8'h14; // Event mask

	// ********************************************************
	// Source codes of the vector register
	// ********************************************************
	localparam logic [6:0] CODE_IDLE = 7'h40; // Nothing pending
	localparam logic [6:0] CODE_BUSERR = 7'h41; // Bus error
	localparam logic [6:0] CODE_WAKE = 7'h42; // Wake-up activity
	localparam logic [6:0] CODE_OVRUN = 7'h43; // Receive overflow
	localparam logic [6:0] CODE_ADDR = 7'h44; // Address error
	localparam logic [6:0] CODE_BW = 7'h45; // Bandwidth error
	localparam logic [6:0] CODE_TSTMP = 7'h46; // Timestamp overflow
	localparam logic [6:0] CODE_MODE = 7'h47; // Mode change done
	localparam logic [6:0] CODE_INVAL = 7'h48; // Invalid message

	// ********************************************************
	// Field positions and error thresholds
	// ********************************************************
	localparam int VEC_FHIT_LSB = 8; // Filter index field base
	localparam int TREC_BO = 21; // Bus-off bit
	localparam int TREC_TXPAS = 20; // Transmit passive bit
	localparam int TREC_RXPAS = 19; // Receive passive bit
	localparam int TREC_TXW = 18; // Transmit warning bit
	localparam int TREC_RXW = 17; // Receive warning bit
	localparam int TREC_EW = 16; // Combined warning bit
	localparam int TREC_TXC_LSB = 8; // Transmit count base
	localparam logic [8:0] LIM_OFF = 9'h100; // Bus-off limit
	localparam logic [8:0] LIM_PASS = 9'h080; // Passive limit
	localparam logic [8:0] LIM_WARN = 9'h060; // Warning limit

	// ********************************************************
	// Event status bits and reset values
	// ********************************************************
	localparam int EV_BO = 0; // Entered bus-off
	localparam int EV_TXPAS = 1; // Transmitter went passive
	localparam int EV_RXPAS = 2; // Receiver went passive
	localparam int EV_WARN = 3; // Warning state entered
	localparam int EV_OVF = 4; // A FIFO newly overflowed
	localparam int EV_W = 5; // Number of event bits
	localparam logic [31:0] VEC_RST = 32'h0000_0040; // Idle code
	localparam logic [31:0] ZERO_RST = 32'h0000_0000; // Cleared regs

endpackage

// ==== logic/csv_status_vector.sv ====
// CAN status vector, error state and FIFO summary register block
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Filter hit index in bits 12..8
// - Codes 0..15 name pending FIFO
// - Bus error, wake, overflow codes 41..43
// - System error: address or bandwidth code
// - Timestamp, mode change, invalid message codes
// - Idle code 40; reserved codes never produced
// - Bus-off when transmit count reaches 256
// - Transmit passive at count 128 up
// - Receive passive at count 128 up
// - Transmit warning for counts 96..127
// - Receive warning for counts 96..127
// - Bit 16 is either warning
// - Error counters readable, reset zero
// - One pending bit per FIFO
// - One overflow bit per FIFO
// - Upper count bits read zero, unwritable
module csv_status_vector (
	input wire logic clk_sys_i, // System clock, 100 MHz
	input wire logic rst_n_i, // Async reset, active low
	input wire logic psel_i, // APB select
	input wire logic penable_i, // APB access phase
	input wire logic pwrite_i, // APB write when high
	input wire logic [7:0] paddr_i, // APB byte address
	input wire logic [31:0] pwdata_i, // APB write data
	input wire logic [3:0] pstrb_i, // APB byte strobes
	output logic [31:0] prdata_o, // APB read data
	output logic pready_o, // APB ready
	output logic pslverr_o, // APB error on unmapped address
	output logic irq_o, // Level interrupt
	input wire logic bus_error_flag_i, // Bus error pending
	input wire logic wakeup_activity_flag_i, // Wake-up pending
	input wire logic receive_overflow_flag_i, // Overflow pending
	input wire logic system_error_flag_i, // System error pending
	input wire logic bandwidth_error_i, // System error is bandwidth
	input wire logic timestamp_overflow_flag_i, // Timer wrapped
	input wire logic mode_change_flag_i, // Mode change done
	input wire logic invalid_message_flag_i, // Bad message seen
	input wire logic [4:0] matched_filter_index_i, // Filter hit
	input wire logic [8:0] transmit_error_count_i, // Tx errors
	input wire logic [7:0] receive_error_count_i, // Rx errors
	input wire logic [15:0] fifo_pending_bits_i, // Per FIFO pending
	input wire logic [15:0] fifo_overflow_bits_i // Per FIFO overflow
);
	import csv_pkg::*;

	// ********************************************************
	// Helper functions
	// ********************************************************

	// Lowest numbered set bit; FIFO 0 wins over FIFO 15
	function automatic logic [3:0] first_set(input logic [15:0] v);
		logic [3:0] idx;
		idx = 4'h0;
		for (int i = 15; i >= 0; i--) begin
			if (v[i]) begin
				idx = 4'(i);
			end
		end
		return idx;
	endfunction

	// Warning band: at least 96 and below 128
	function automatic logic in_warn(input logic [8:0] c);
		return (c >= LIM_WARN) && (c < LIM_PASS);
	endfunction

	// ********************************************************
	// Declarations
	// ********************************************************
	logic [31:0] vec_q; // Vector register
	logic [31:0] vec_d; // Next vector value
	logic [31:0] trec_q; // Error count register
	logic [31:0] trec_d; // Next error count value
	logic [15:0] fstat_q; // FIFO pending summary
	logic [15:0] ovf_q; // FIFO overflow summary
	logic [EV_W-1:0] stat_q; // Sticky event bits
	logic [EV_W-1:0] stat_d; // Next sticky value
	logic [EV_W-1:0] mask_q; // Event mask
	logic [EV_W-1:0] ev; // One-cycle event pulses
	logic [EV_W-1:0] clr; // Write-one-to-clear bits
	logic [6:0] src_code; // Selected source code
	logic [6:0] sys_code; // Which system error code
	logic [3:0] fifo_idx; // Lowest pending FIFO
	logic [8:0] rx_wide; // Receive count widened
	logic [7:0] tx_shown; // Transmit count as shown
	logic tx_off; // Transmitter bus-off
	logic tx_pas; // Transmitter passive
	logic rx_pas; // Receiver passive
	logic tx_wrn; // Transmitter warning
	logic rx_wrn; // Receiver warning
	logic setup; // APB setup cycle
	logic acc; // APB access completes
	logic wr; // Completing write
	logic hit_vec; // Address decodes
	logic hit_trec;
	logic hit_fstat;
	logic hit_ovf;
	logic hit_istat;
	logic hit_imask;
	logic mapped; // Any register hit
	logic [31:0] rdata_d; // Read mux output
	logic [31:0] prdata_q; // Read data flop
	logic pready_q; // Ready flop
	logic pslverr_q; // Error flop
	logic irq_q; // Interrupt flop

	// ********************************************************
	// Source code selection
	// ********************************************************

	assign fifo_idx = first_set(fifo_pending_bits_i);
	// One flag drives two codes; the qualifier picks which
	assign sys_code = bandwidth_error_i ? CODE_BW : CODE_ADDR;

	// Fixed priority: module events first, then FIFOs
	assign src_code =
		bus_error_flag_i ? CODE_BUSERR :
		wakeup_activity_flag_i ? CODE_WAKE :
		receive_overflow_flag_i ? CODE_OVRUN :
		system_error_flag_i ? sys_code :
		timestamp_overflow_flag_i ? CODE_TSTMP :
		mode_change_flag_i ? CODE_MODE :
		invalid_message_flag_i ? CODE_INVAL :
		(|fifo_pending_bits_i) ? {3'b000, fifo_idx} :
		CODE_IDLE;

	// Reserved filter codes pass through; the filter owns them
	assign vec_d = {19'h0, matched_filter_index_i, 1'b0, src_code};

	// ********************************************************
	// Error state decode
	// ********************************************************

	assign rx_wide = {1'b0, receive_error_count_i};
	assign tx_off = transmit_error_count_i >= LIM_OFF;
	assign tx_pas = transmit_error_count_i >= LIM_PASS;
	assign rx_pas = rx_wide >= LIM_PASS;
	assign tx_wrn = in_warn(transmit_error_count_i);
	assign rx_wrn = in_warn(rx_wide);
	// The field is 8 bits; above 255 it saturates at 255
	assign tx_shown = transmit_error_count_i[8] ? 8'hff :
		transmit_error_count_i[7:0];

	// Upper bits tied low; no write path reaches them
	assign trec_d = {10'h000, tx_off, tx_pas, rx_pas, tx_wrn,
		rx_wrn, tx_wrn | rx_wrn, tx_shown,
		receive_error_count_i};

	// ********************************************************
	// Status snapshot registers
	// ********************************************************

	// Every status field is re-sampled each cycle
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			vec_q <= VEC_RST;
			trec_q <= ZERO_RST;
			fstat_q <= 16'h0000;
			ovf_q <= 16'h0000;
		end else begin
			vec_q <= vec_d;
			trec_q <= trec_d;
			fstat_q <= fifo_pending_bits_i;
			ovf_q <= fifo_overflow_bits_i;
		end
	end

	// ********************************************************
	// Interrupt events
	// ********************************************************

	// Rising edges of the decoded states mark entry events
	assign ev[EV_BO] = trec_d[TREC_BO] & ~trec_q[TREC_BO];
	assign ev[EV_TXPAS] = trec_d[TREC_TXPAS] & ~trec_q[TREC_TXPAS];
	assign ev[EV_RXPAS] = trec_d[TREC_RXPAS] & ~trec_q[TREC_RXPAS];
	assign ev[EV_WARN] = trec_d[TREC_EW] & ~trec_q[TREC_EW];
	assign ev[EV_OVF] = |(fifo_overflow_bits_i & ~ovf_q);

	// Write one to clear, low byte lane only
	assign clr = (wr && hit_istat && pstrb_i[0]) ?
		pwdata_i[EV_W-1:0] : '0;
	// A new event beats a clear in the same cycle
	assign stat_d = (stat_q & ~clr) | ev;

	// Sticky status, mask and interrupt level
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stat_q <= '0;
			mask_q <= '0;
			irq_q <= 1'b0;
		end else begin
			stat_q <= stat_d;
			if (wr && hit_imask && pstrb_i[0]) begin
				mask_q <= pwdata_i[EV_W-1:0];
			end
			irq_q <= |(stat_d & mask_q);
		end
	end

	// ********************************************************
	// APB slave
	// ********************************************************

	assign setup = psel_i & ~penable_i;
	assign acc = psel_i & penable_i & pready_q;
	assign wr = acc & pwrite_i;
	assign hit_vec = paddr_i == OFF_VEC;
	assign hit_trec = paddr_i == OFF_TREC;
	assign hit_fstat = paddr_i == OFF_FSTAT;
	assign hit_ovf = paddr_i == OFF_OVFSUM;
	assign hit_istat = paddr_i == OFF_ISTAT;
	assign hit_imask = paddr_i == OFF_IMASK;
	assign mapped = hit_vec | hit_trec | hit_fstat | hit_ovf |
		hit_istat | hit_imask;

	// Read mux; unmapped reads return zero
	assign rdata_d =
		hit_vec ? vec_q :
		hit_trec ? trec_q :
		hit_fstat ? {16'h0000, fstat_q} :
		hit_ovf ? {16'h0000, ovf_q} :
		hit_istat ? {27'h0, stat_q} :
		hit_imask ? {27'h0, mask_q} :
		32'h0000_0000;

	// Ready rises in the first access cycle: one wait-free answer
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= ZERO_RST;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup & ~mapped;
			if (setup && !pwrite_i) begin
				prdata_q <= rdata_d;
			end
		end
	end

	assign prdata_o = prdata_q;
	assign pready_o = pready_q;
	assign pslverr_o = pslverr_q;
	assign irq_o = irq_q;

	// ********************************************************
	// Assertions
	// ********************************************************

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	property p_fhit;
		##1 vec_q[12:8] == $past(matched_filter_index_i);
	endproperty
	a_fhit: assert property (p_fhit) else $error("filter index");

	property p_fifo;
		(!bus_error_flag_i && !wakeup_activity_flag_i &&
		!receive_overflow_flag_i && !system_error_flag_i &&
		!timestamp_overflow_flag_i && !mode_change_flag_i &&
		!invalid_message_flag_i && fifo_pending_bits_i[0])
		|=> vec_q[6:0] == 7'h00;
	endproperty
	a_fifo: assert property (p_fifo) else $error("fifo code");

	property p_buserr;
		bus_error_flag_i |=> vec_q[6:0] == CODE_BUSERR;
	endproperty
	a_buserr: assert property (p_buserr) else $error("bus err");

	property p_sys;
		(system_error_flag_i && !bus_error_flag_i &&
		!wakeup_activity_flag_i && !receive_overflow_flag_i)
		|=> vec_q[6:0] == ($past(bandwidth_error_i) ? CODE_BW :
		CODE_ADDR);
	endproperty
	a_sys: assert property (p_sys) else $error("sys code");

	property p_reserved;
		!(vec_q[6:0] inside {[7'h10:7'h3f], [7'h49:7'h7f]});
	endproperty
	a_reserved: assert property (p_reserved) else $error("rsv");

	property p_busoff;
		(transmit_error_count_i >= 9'h100) |=> trec_q[TREC_BO];
	endproperty
	a_busoff: assert property (p_busoff) else $error("bus off");

	property p_txpas;
		##1 trec_q[TREC_TXPAS] ==
		($past(transmit_error_count_i) >= 9'h080);
	endproperty
	a_txpas: assert property (p_txpas) else $error("tx pas");

	property p_rxpas;
		##1 trec_q[TREC_RXPAS] == $past(receive_error_count_i[7]);
	endproperty
	a_rxpas: assert property (p_rxpas) else $error("rx pas");

	property p_warn;
		##1 trec_q[TREC_EW] == (trec_q[TREC_TXW] | trec_q[TREC_RXW])
		&& trec_q[TREC_TXW] == ($past(transmit_error_count_i) >= 9'h060
		&& $past(transmit_error_count_i) < 9'h080);
	endproperty
	a_warn: assert property (p_warn) else $error("warn");

	property p_upper;
		trec_q[31:22] == 10'h000;
	endproperty
	a_upper: assert property (p_upper) else $error("upper");

	property p_sums;
		##1 fstat_q == $past(fifo_pending_bits_i) &&
		ovf_q == $past(fifo_overflow_bits_i);
	endproperty
	a_sums: assert property (p_sums) else $error("sums");

	// A clear in the same cycle may drop the line, so leave it out
	property p_irq;
		(stat_q & ~clr & mask_q) != '0 |=> irq_o;
	endproperty
	a_irq: assert property (p_irq) else $error("irq level");

	// No unmasked status left means the line drops next edge
	property p_irq_off;
		(stat_d & mask_q) == '0 |=> !irq_o;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq stuck");

	property p_receiver_warning;
		##1 trec_q[TREC_RXW] == ($past(receive_error_count_i) >= 8'h60
		&& $past(receive_error_count_i) < 8'h80);
	endproperty
	a_receiver_warning: assert property (p_receiver_warning) else $error("rx warn");

	// The shown transmit count saturates; bus-off lives in bit 21
	property p_counts;
		##1 trec_q[7:0] == $past(receive_error_count_i) &&
		trec_q[15:8] == ($past(transmit_error_count_i[8]) ? 8'hff :
		$past(transmit_error_count_i[7:0]));
	endproperty
	a_counts: assert property (p_counts) else $error("counts");

	property p_tstmp;
		(timestamp_overflow_flag_i && !bus_error_flag_i &&
		!wakeup_activity_flag_i && !receive_overflow_flag_i &&
		!system_error_flag_i) |=> vec_q[6:0] == CODE_TSTMP;
	endproperty
	a_tstmp: assert property (p_tstmp) else $error("timer code");

	// Idle code whenever nothing at all is pending
	property p_idle;
		(!bus_error_flag_i && !wakeup_activity_flag_i &&
		!receive_overflow_flag_i && !system_error_flag_i &&
		!timestamp_overflow_flag_i && !mode_change_flag_i &&
		!invalid_message_flag_i && fifo_pending_bits_i == 16'h0000)
		|=> vec_q[6:0] == CODE_IDLE;
	endproperty
	a_idle: assert property (p_idle) else $error("idle code");

	c_idle: cover property (vec_q[6:0] == CODE_IDLE ##1
		vec_q[6:0] == CODE_BUSERR);
	c_busoff: cover property ($rose(trec_q[TREC_BO]));
	c_irq: cover property ($rose(irq_o));
	c_read: cover property (acc && !pwrite_i && hit_trec);
	c_bw: cover property (vec_q[6:0] == CODE_BW);

endmodule // csv_status_vector

`default_nettype wire

// ==== testbench/csv_can_node_model.sv ====
// Model of the CAN node side that feeds the error counters
`timescale 1ns/1ps
`default_nettype none

module csv_can_node_model (
	input wire logic clk_sys_i, // System clock
	input wire logic rst_n_i, // Async reset, active low
	input wire logic load_i, // Take new counts
	input wire logic [8:0] tx_i, // New transmit count
	input wire logic [7:0] rx_i, // New receive count
	output logic [8:0] tec_o, // Transmit error count
	output logic [7:0] rec_o // Receive error count
);

	// ********************************************************
	// Error bookkeeping of the node
	// ********************************************************
	// Counts jump on load so thresholds are reached in a few cycles
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin // Counts start at zero
			tec_o <= 9'h000;
			rec_o <= 8'h00;
		end else if (load_i) begin // New counts from the bench
			tec_o <= tx_i;
			rec_o <= rx_i;
		end
	end

endmodule // csv_can_node_model
`default_nettype wire

// ==== testbench/csv_status_vector_test.sv ====
// Self-checking bench for the CAN status vector register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e, m) begin checked++; if ((a) !== (e)) begin \
	num_errors++; $display("wrong value at %0t: %s got %h want %h", \
	$time, m, a, e); end end

module csv_status_vector_test;
	import csv_pkg::*;

	// ********************************************************
	// Signals
	// ********************************************************
	logic clk_sys_i = 1'b0, rst_n_i = 1'b0; // Clock and reset
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB control
	logic [7:0] paddr = 8'h00; // APB address
	logic [31:0] pwdata = 32'h0, prdata, rd; // APB data
	logic pready, pslverr, irq, er; // Design answers
	logic [6:0] flg = 7'h00; // Event flags, highest priority first
	logic bw = 1'b0; // System error is bandwidth
	logic [4:0] fidx = 5'h00; // Filter hit
	logic [15:0] fpend = 16'h0, fovf = 16'h0; // FIFO summaries
	logic ld = 1'b0; // Counter load strobe
	logic [3:0] strb = 4'hf; // APB byte strobes
	logic [8:0] ltx = 9'h000, tec; // Transmit counts
	logic [7:0] lrx = 8'h00, rec; // Receive counts
	int num_errors = 0, checked = 0, cycles = 0; // Tallies
	logic [6:0] cd [7] = '{7'h41, 7'h42, 7'h43, 7'h44, 7'h46, 7'h47,
		7'h48}; // Code of the top flag in each priority step
	logic [8:0] tt [10] = '{9'h000, 9'h05f, 9'h060, 9'h07f, 9'h080,
		9'h0ff, 9'h100, 9'h064, 9'h000, 9'h000}; // Tx counts
	logic [7:0] rt [10] = '{8'h00, 8'h5f, 8'h60, 8'h7f, 8'h80, 8'hff,
		8'h00, 8'h00, 8'h64, 8'h00}; // Rx counts around each limit

	always #5 clk_sys_i = ~clk_sys_i; // 100 MHz

	csv_can_node_model u_csv_can_node_model (.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i), .load_i(ld), .tx_i(ltx), .rx_i(lrx),
		.tec_o(tec), .rec_o(rec));

	csv_status_vector u_csv_status_vector (.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.pstrb_i(strb), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .irq_o(irq), .bus_error_flag_i(flg[0]),
		.wakeup_activity_flag_i(flg[1]), .receive_overflow_flag_i(flg[2]),
		.system_error_flag_i(flg[3]), .bandwidth_error_i(bw),
		.timestamp_overflow_flag_i(flg[4]), .mode_change_flag_i(flg[5]),
		.invalid_message_flag_i(flg[6]), .matched_filter_index_i(fidx),
		.transmit_error_count_i(tec), .receive_error_count_i(rec),
		.fifo_pending_bits_i(fpend), .fifo_overflow_bits_i(fovf));

	// ********************************************************
	// Bus and stimulus tasks
	// ********************************************************
	// One APB transfer; waits on pready, the hang guard ends a dead wait
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		@(posedge clk_sys_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_sys_i);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys_i);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Read a register and compare with no error expected
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
		input string m);
		apb(1'b0, a, 32'h0);
		`CHK(rd, e, m)
		`CHK(er, 1'b0, m)
	endtask

	// Counts pass through the node model, so allow it one more edge
	task automatic load(input logic [8:0] t, input logic [7:0] r);
		@(posedge clk_sys_i);
		ld <= 1'b1;
		ltx <= t;
		lrx <= r;
		@(posedge clk_sys_i);
		ld <= 1'b0;
		@(posedge clk_sys_i);
	endtask

	// Expected error word worked out from the thresholds
	function automatic logic [31:0] trec(input logic [8:0] t,
		input logic [7:0] r);
		logic tw, rw;
		tw = t >= 9'h060 && t < 9'h080;
		rw = r >= 8'h60 && r < 8'h80;
		trec = {10'h0, t >= 9'h100, t >= 9'h080, r >= 8'h80, tw, rw,
			tw | rw, (t > 9'h0ff) ? 8'hff : t[7:0], r};
	endfunction

	task automatic tally_and_finish();
		$display("comparisons %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Hang guard: the sequence needs about 290 cycles
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles >= 6000) begin
			num_errors++;
			tally_and_finish();
		end
	end

	// ********************************************************
	// Main sequence
	// ********************************************************
	initial begin
		repeat (12) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		rdchk(OFF_VEC, 32'h40, "vec reset");
		for (int k = 1; k < 6; k++) begin // All other words clear
			rdchk(8'(k * 4), 32'h0, "reset zero");
		end
		// Strip flags from the top; FIFOs pending must lose throughout
		for (int i = 0; i < 7; i++) begin
			@(posedge clk_sys_i);
			flg <= 7'h7f << i;
			fpend <= 16'hffff;
			rdchk(OFF_VEC, {25'h0, cd[i]}, "priority");
		end
		@(posedge clk_sys_i);
		flg <= 7'h08;
		bw <= 1'b1;
		rdchk(OFF_VEC, 32'h45, "bandwidth");
		// FIFO codes with the filter index riding along
		for (int j = 0; j < 16; j++) begin
			@(posedge clk_sys_i);
			flg <= 7'h00;
			fidx <= 5'(j);
			fpend <= 16'hffff << j;
			rdchk(OFF_VEC, {19'h0, 5'(j), 4'h0, 4'(j)}, "fifo");
			rdchk(OFF_FSTAT, {16'h0, 16'hffff << j}, "pend");
		end
		@(posedge clk_sys_i);
		fpend <= 16'h0;
		rdchk(OFF_VEC, 32'h00000f40, "idle");
		for (int i = 0; i < 10; i++) begin // Walk every limit
			load(tt[i], rt[i]);
			rdchk(OFF_TREC, trec(tt[i], rt[i]), "cnt");
		end
		@(posedge clk_sys_i);
		fovf <= 16'ha5c3;
		rdchk(OFF_OVFSUM, 32'h0000a5c3, "overflow");
		rdchk(OFF_ISTAT, 32'h1f, "events");
		`CHK(irq, 1'b0, "masked irq")
		apb(1'b1, OFF_TREC, 32'hffffffff);
		rdchk(OFF_TREC, 32'h0, "read only");
		apb(1'b0, 8'h18, 32'h0);
		`CHK(er, 1'b1, "unmapped err")
		`CHK(rd, 32'h0, "unmapped data")
		// Mask, clear and raise the interrupt
		apb(1'b1, OFF_IMASK, 32'h1);
		rdchk(OFF_IMASK, 32'h1, "mask");
		`CHK(irq, 1'b1, "irq on")
		apb(1'b1, OFF_ISTAT, 32'h1);
		rdchk(OFF_ISTAT, 32'h1e, "w1c");
		`CHK(irq, 1'b0, "irq off")
		apb(1'b1, OFF_IMASK, 32'h1f);
		rdchk(OFF_IMASK, 32'h1f, "mask all");
		`CHK(irq, 1'b1, "irq others")
		apb(1'b1, OFF_ISTAT, 32'h1e);
		rdchk(OFF_ISTAT, 32'h0, "cleared");
		`CHK(irq, 1'b0, "irq clear")
		strb <= 4'h0; // Low lane off: the mask write must not land
		apb(1'b1, OFF_IMASK, 32'h0);
		strb <= 4'hf;
		rdchk(OFF_IMASK, 32'h1f, "strobe off");
		load(9'h100, 8'h00);
		rdchk(OFF_ISTAT, 32'h3, "bus off event");
		`CHK(irq, 1'b1, "irq event")
		tally_and_finish();
	end

endmodule // csv_status_vector_test
`default_nettype wire
